//--- hdl/lpmc_top.sv
// low-power mode controller: mode sequencing, regulator and clock control, axi4-lite regs
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module lpmc_top
    import lpmc_pkg::*;
#(
    parameter int OSC_WAIT = OSC_START_CYC,
    parameter int RST_WAIT = RST_HOLD_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins and sources
    input wire logic bypass_reg,
    input wire logic core_por_pin_n,
    input wire logic system_reset_pin_n,
    input wire logic battery_supply_mode,
    input wire logic [EXT_LINES-1:0] external_event_lines,
    input wire logic supply_level_detector,
    input wire logic usb_wakeup,
    input wire logic eth_wakeup,
    input wire logic low_power_timer,
    input wire lpmc_rtc_evt_t rtc_evt,
    input wire logic periph_irq,
    input wire logic ext_low_speed_osc,
    input wire logic int_low_speed_rc,
    input wire logic ext_high_speed_osc,
    // outputs
    output lpmc_reg_ctl_t reg_ctl,
    output lpmc_clk_ctl_t clk_ctl,
    output logic core_rst_n,
    output logic core_por_gpio_en,
    output logic debug_por_en,
    output logic rtc_clk,
    output logic rtc_run,
    output logic irq
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    initial begin
        if (OSC_WAIT < 1 || OSC_WAIT > 65535 || RST_WAIT < 1 || RST_WAIT > 65535) begin
            $error("lpmc_top: wait counts out of range");
        end
    end

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // allowed regulator configuration per requested mode
    function automatic logic cfg_ok(input lpmc_req_t m, input logic lpsel,
                                    input lpmc_drv_t d, input logic byp);
        logic ok;
        ok = 1'b0;
        case (m)
            LPMC_REQ_RUN, LPMC_REQ_SLEEP: ok = !lpsel && (d == LPMC_DRV_NORMAL ||
                                                          d == LPMC_DRV_OVER);
            LPMC_REQ_STOP: ok = d == LPMC_DRV_NORMAL || d == LPMC_DRV_UNDER;
            LPMC_REQ_STANDBY: ok = !byp;
            default: ok = 1'b0;
        endcase
        if (byp && d != LPMC_DRV_NORMAL) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    // ------------------------------------------------------------
    // wakeup sources
    // ------------------------------------------------------------
    logic rtc_any;
    logic ext_wake_any;
    logic [WK_W-1:0] wk_vec;
    logic [31:0] wken_r;
    logic [31:0] wken_nxt;

    assign rtc_any = |rtc_evt;
    assign wk_vec = {low_power_timer, eth_wakeup | usb_wakeup, supply_level_detector,
                     rtc_any, external_event_lines};
    assign ext_wake_any = |(wk_vec & wken_r[WK_W-1:0]);

    // ------------------------------------------------------------
    // registers and bus
    // ------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic [IRQ_W-1:0] irqs_r;
    logic [IRQ_W-1:0] irqs_nxt;
    logic [IRQ_W-1:0] irqm_r;
    logic [IRQ_W-1:0] irqm_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;
    logic wr_go;
    logic rd_go;
    logic enter_req;
    logic reject_evt;
    logic wake_evt;
    lpmc_state_t st_r;
    lpmc_state_t st_nxt;

    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign rd_go = s_axi_arvalid && !rvalid_r;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign enter_req = wr_go && is_addr(s_axi_awaddr, LPMC_CTRL_OFF) &&
                       s_axi_wstrb[1] && s_axi_wdata[CTRL_ENTER_BIT];

    always_comb begin
        logic [31:0] wd;
        wd = s_axi_wdata;
        ctrl_nxt = ctrl_r;
        irqm_nxt = irqm_r;
        wken_nxt = wken_r;
        irqs_nxt = irqs_r;
        bvalid_nxt = bvalid_r && !s_axi_bready;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r && !s_axi_rready;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (wr_go) begin
            bvalid_nxt = 1'b1;
            bresp_nxt = 2'b00;
            for (int b = 0; b < 4; b++) begin
                if (s_axi_wstrb[b]) begin
                    if (is_addr(s_axi_awaddr, LPMC_CTRL_OFF)) begin
                        ctrl_nxt[b*8 +: 8] = wd[b*8 +: 8];
                    end
                    if (is_addr(s_axi_awaddr, LPMC_WKEN_OFF)) begin
                        wken_nxt[b*8 +: 8] = wd[b*8 +: 8];
                    end
                end
            end
            if (is_addr(s_axi_awaddr, LPMC_IRQM_OFF) && s_axi_wstrb[0]) begin
                irqm_nxt = wd[IRQ_W-1:0];
            end
            if (!(is_addr(s_axi_awaddr, LPMC_CTRL_OFF) || is_addr(s_axi_awaddr, LPMC_IRQM_OFF)
                  || is_addr(s_axi_awaddr, LPMC_WKEN_OFF) || is_addr(s_axi_awaddr, LPMC_STAT_OFF)
                  || is_addr(s_axi_awaddr, LPMC_IRQS_OFF))) begin
                bresp_nxt = 2'b10;
            end
            // enter bit is a trigger, not stored
            ctrl_nxt[CTRL_ENTER_BIT] = 1'b0;
        end
        if (rd_go) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = 2'b00;
            rdata_nxt = 32'h0000_0000;
            if (is_addr(s_axi_araddr, LPMC_CTRL_OFF)) begin
                rdata_nxt = ctrl_r;
            end else if (is_addr(s_axi_araddr, LPMC_STAT_OFF)) begin
                rdata_nxt = {16'h0000, st_r, bypass_reg, battery_supply_mode,
                             reg_ctl};
            end else if (is_addr(s_axi_araddr, LPMC_IRQS_OFF)) begin
                rdata_nxt[IRQ_W-1:0] = irqs_r;
                // read clears
                irqs_nxt = '0;
            end else if (is_addr(s_axi_araddr, LPMC_IRQM_OFF)) begin
                rdata_nxt[IRQ_W-1:0] = irqm_r;
            end else if (is_addr(s_axi_araddr, LPMC_WKEN_OFF)) begin
                rdata_nxt = wken_r;
            end else begin
                rresp_nxt = 2'b10;
            end
        end
        // set wins over read-clear
        if (reject_evt) begin
            irqs_nxt[IRQ_REJECT] = 1'b1;
        end
        if (wake_evt) begin
            irqs_nxt[IRQ_WAKE] = 1'b1;
        end
        if (rtc_any) begin
            irqs_nxt[IRQ_RTC] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RESET;
            wken_r <= WKEN_RESET;
            irqs_r <= '0;
            irqm_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'b00;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= 2'b00;
        end else begin
            ctrl_r <= ctrl_nxt;
            wken_r <= wken_nxt;
            irqs_r <= irqs_nxt;
            irqm_r <= irqm_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign irq = |(irqs_r & irqm_r);

    // ------------------------------------------------------------
    // mode sequencer
    // ------------------------------------------------------------
    lpmc_req_t req_mode;
    lpmc_drv_t req_drv;
    logic req_lp;
    logic [1:0] act_drv_r;
    logic [1:0] act_drv_nxt;
    logic act_lp_r;
    logic act_lp_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic lost_r;
    logic lost_nxt;

    assign req_mode = lpmc_req_t'(s_axi_wdata[CTRL_MODE_LSB +: 2]);
    assign req_drv = lpmc_drv_t'(s_axi_wdata[CTRL_DRIVE_LSB +: 2]);
    assign req_lp = s_axi_wdata[CTRL_REGSEL_BIT];

    always_comb begin
        st_nxt = st_r;
        act_drv_nxt = act_drv_r;
        act_lp_nxt = act_lp_r;
        cnt_nxt = (cnt_r != 16'h0000) ? cnt_r - 16'h0001 : 16'h0000;
        lost_nxt = lost_r;
        reject_evt = 1'b0;
        wake_evt = 1'b0;
        case (st_r)
            LPMC_ST_RUN: begin
                if (enter_req) begin
                    // bypass refuses drive modes and standby
                    if (!cfg_ok(req_mode, req_lp, req_drv, bypass_reg)) begin
                        reject_evt = 1'b1;
                    end else begin
                        act_drv_nxt = req_drv;
                        act_lp_nxt = req_lp;
                        case (req_mode)
                            LPMC_REQ_SLEEP: st_nxt = LPMC_ST_SLEEP;
                            LPMC_REQ_STOP: st_nxt = LPMC_ST_STOP;
                            LPMC_REQ_STANDBY: st_nxt = LPMC_ST_STANDBY;
                            default: st_nxt = LPMC_ST_RUN;
                        endcase
                    end
                end
            end
            LPMC_ST_SLEEP: begin
                // any peripheral event wakes the cpu
                if (periph_irq || ext_wake_any) begin
                    st_nxt = LPMC_ST_RUN;
                    wake_evt = 1'b1;
                end
            end
            LPMC_ST_STOP: begin
                if (ext_wake_any) begin
                    st_nxt = LPMC_ST_OSC_WAIT;
                    cnt_nxt = 16'(OSC_WAIT);
                    wake_evt = 1'b1;
                end
            end
            LPMC_ST_STANDBY: begin
                if (ext_wake_any) begin
                    lost_nxt = 1'b1;
                    st_nxt = LPMC_ST_OSC_WAIT;
                    cnt_nxt = 16'(OSC_WAIT);
                    wake_evt = 1'b1;
                end
            end
            LPMC_ST_OSC_WAIT: begin
                if (cnt_r == 16'h0000) begin
                    st_nxt = LPMC_ST_PLL_WAIT;
                    cnt_nxt = 16'(OSC_WAIT);
                end
            end
            LPMC_ST_PLL_WAIT: begin
                if (cnt_r == 16'h0000) begin
                    act_drv_nxt = LPMC_DRV_NORMAL;
                    act_lp_nxt = 1'b0;
                    // standby exit goes through core reset
                    if (lost_r) begin
                        st_nxt = LPMC_ST_CORE_RST;
                        cnt_nxt = 16'(RST_WAIT);
                    end else begin
                        st_nxt = LPMC_ST_RUN;
                    end
                end
            end
            LPMC_ST_CORE_RST: begin
                if (cnt_r == 16'h0000) begin
                    lost_nxt = 1'b0;
                    st_nxt = LPMC_ST_RUN;
                end
            end
            default: st_nxt = LPMC_ST_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= LPMC_ST_RUN;
            act_drv_r <= LPMC_DRV_NORMAL;
            act_lp_r <= 1'b0;
            cnt_r <= 16'h0000;
            lost_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            act_drv_r <= act_drv_nxt;
            act_lp_r <= act_lp_nxt;
            cnt_r <= cnt_nxt;
            lost_r <= lost_nxt;
        end
    end

    // ------------------------------------------------------------
    // regulator, clock and reset outputs
    // ------------------------------------------------------------
    lpmc_reg_ctl_t reg_nxt;
    lpmc_clk_ctl_t clk_nxt;
    logic core_rst_nxt;
    logic rtc_run_nxt;
    logic [4:0] hs_div_r;
    logic [4:0] hs_div_nxt;
    logic rtc_clk_nxt;
    lpmc_rtc_t rtc_sel;

    assign rtc_sel = lpmc_rtc_t'(ctrl_r[CTRL_RTCSEL_LSB +: 2]);

    always_comb begin
        logic in_stop;
        logic in_stby;
        in_stop = st_r == LPMC_ST_STOP;
        in_stby = st_r == LPMC_ST_STANDBY;
        reg_nxt.main_regulator = !in_stby && !(in_stop && act_lp_r) && !bypass_reg;
        reg_nxt.low_power_regulator = in_stop && act_lp_r && !bypass_reg;
        reg_nxt.over_drive = act_drv_r == LPMC_DRV_OVER && !bypass_reg && !in_stby;
        reg_nxt.under_drive = act_drv_r == LPMC_DRV_UNDER && in_stop && !bypass_reg;
        reg_nxt.power_down = in_stby;
        reg_nxt.vscale_en = !bypass_reg;
        reg_nxt.vmon_en = !bypass_reg;
        // sleep gates only the cpu clock
        clk_nxt.cpu_clk_en = st_r == LPMC_ST_RUN;
        // stop gates core clocks, pll and oscillators
        clk_nxt.core_clk_en = !(in_stop || in_stby || st_r == LPMC_ST_OSC_WAIT ||
                                st_r == LPMC_ST_PLL_WAIT);
        clk_nxt.pll_en = !(in_stop || in_stby || st_r == LPMC_ST_OSC_WAIT);
        clk_nxt.int_high_speed_rc_en = !(in_stop || in_stby);
        clk_nxt.ext_high_speed_osc_en = !(in_stop || in_stby);
        // bypass: core por pin resets the core domain
        core_rst_nxt = system_reset_pin_n && !in_stby && st_r != LPMC_ST_CORE_RST &&
                       !(bypass_reg && !core_por_pin_n);
        // battery mode keeps only the external low-speed source
        rtc_run_nxt = (rtc_sel == LPMC_RTC_EXT_LS) ||
                      (rtc_sel == LPMC_RTC_INT_RC && !battery_supply_mode) ||
                      (rtc_sel == LPMC_RTC_HS_DIV && !battery_supply_mode &&
                       clk_nxt.ext_high_speed_osc_en);
        hs_div_nxt = hs_div_r + 5'h01;
        // rtc clock source select, high-speed divided by 32
        case (rtc_sel)
            LPMC_RTC_EXT_LS: rtc_clk_nxt = ext_low_speed_osc;
            LPMC_RTC_INT_RC: rtc_clk_nxt = int_low_speed_rc;
            LPMC_RTC_HS_DIV: rtc_clk_nxt = hs_div_r[4];
            default: rtc_clk_nxt = 1'b0;
        endcase
    end

    // divider counts edges of the high-speed clock, sampled as a level
    logic hs_q_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_ctl <= '0;
            clk_ctl <= '0;
            core_rst_n <= 1'b0;
            rtc_run <= 1'b0;
            rtc_clk <= 1'b0;
            hs_div_r <= 5'h00;
            hs_q_r <= 1'b0;
        end else begin
            reg_ctl <= reg_nxt;
            clk_ctl <= clk_nxt;
            core_rst_n <= core_rst_nxt;
            rtc_run <= rtc_run_nxt;
            rtc_clk <= rtc_clk_nxt;
            hs_q_r <= ext_high_speed_osc;
            hs_div_r <= (ext_high_speed_osc && !hs_q_r) ? hs_div_nxt : hs_div_r;
        end
    end

    // bypass removes general i/o use of the core por pin
    assign core_por_gpio_en = !bypass_reg;
    // in bypass, debug under reset only while core por pin is high
    assign debug_por_en = !(bypass_reg && !core_por_pin_n);

endmodule

//--- hdl/lpmc_pkg.sv
// package: constants, types and register map of the low-power mode controller
package lpmc_pkg;

    // ------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] LPMC_CTRL_OFF = 8'h00;
    localparam logic [7:0] LPMC_STAT_OFF = 8'h04;
    localparam logic [7:0] LPMC_IRQS_OFF = 8'h08;
    localparam logic [7:0] LPMC_IRQM_OFF = 8'h0C;
    localparam logic [7:0] LPMC_WKEN_OFF = 8'h10;

    // ctrl fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_REGSEL_BIT = 2;
    localparam int CTRL_DRIVE_LSB = 3;
    localparam int CTRL_RTCSEL_LSB = 5;
    localparam int CTRL_ENTER_BIT = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] WKEN_RESET = 32'hFFFF_FFFF;

    // irq status bits
    localparam int IRQ_REJECT = 0;
    localparam int IRQ_WAKE = 1;
    localparam int IRQ_RTC = 2;
    localparam int IRQ_W = 3;

    // wakeup sources
    localparam int EXT_LINES = 16;
    localparam int WK_W = EXT_LINES + 4;

    // restart timing
    localparam int CLK_HZ = 20_000_000;
    localparam int OSC_START_NS = 1000;
    localparam int OSC_START_CYC =
        (OSC_START_NS * (CLK_HZ / 1_000_000) + 999) / 1000 < 1 ? 1 :
        (OSC_START_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int RST_HOLD_CYC = 4;

    // requested mode code
    typedef enum logic [1:0] {
        LPMC_REQ_RUN = 2'h0,
        LPMC_REQ_SLEEP = 2'h1,
        LPMC_REQ_STOP = 2'h2,
        LPMC_REQ_STANDBY = 2'h3
    } lpmc_req_t;

    // regulator drive
    typedef enum logic [1:0] {
        LPMC_DRV_NORMAL = 2'h0,
        LPMC_DRV_OVER = 2'h1,
        LPMC_DRV_UNDER = 2'h2,
        LPMC_DRV_BAD = 2'h3
    } lpmc_drv_t;

    // rtc source
    typedef enum logic [1:0] {
        LPMC_RTC_NONE = 2'h0,
        LPMC_RTC_EXT_LS = 2'h1,
        LPMC_RTC_INT_RC = 2'h2,
        LPMC_RTC_HS_DIV = 2'h3
    } lpmc_rtc_t;

    // controller state, one-hot
    typedef enum logic [6:0] {
        LPMC_ST_RUN = 7'h01,
        LPMC_ST_SLEEP = 7'h02,
        LPMC_ST_STOP = 7'h04,
        LPMC_ST_STANDBY = 7'h08,
        LPMC_ST_OSC_WAIT = 7'h10,
        LPMC_ST_PLL_WAIT = 7'h20,
        LPMC_ST_CORE_RST = 7'h40
    } lpmc_state_t;

    // regulator and clock outputs
    typedef struct packed {
        logic main_regulator;
        logic low_power_regulator;
        logic over_drive;
        logic under_drive;
        logic power_down;
        logic vscale_en;
        logic vmon_en;
    } lpmc_reg_ctl_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic core_clk_en;
        logic pll_en;
        logic int_high_speed_rc_en;
        logic ext_high_speed_osc_en;
    } lpmc_clk_ctl_t;

    // rtc event group
    typedef struct packed {
        logic alarm;
        logic wakeup_timer;
        logic timestamp;
        logic tamper;
    } lpmc_rtc_evt_t;

endpackage

//--- bench/lpmc_sva.sv
// checker: port assertions of the mode controller
`timescale 1ns/100ps
module lpmc_sva
    import lpmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bypass_reg,
    input wire logic core_por_pin_n,
    input wire lpmc_reg_ctl_t reg_ctl,
    input wire lpmc_clk_ctl_t clk_ctl,
    input wire logic core_por_gpio_en,
    input wire logic debug_por_en
);
    // ----
    // pins, regulator and clock gating
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_gpio_off: assert property (core_por_gpio_en == !bypass_reg)
        else $error("gpio enable");
    chk_debug_por: assert property (
        debug_por_en == !(bypass_reg && !core_por_pin_n)) else $error("debug enable");
    chk_bypass_mon: assert property (bypass_reg && $past(bypass_reg) |->
        !reg_ctl.vscale_en && !reg_ctl.vmon_en) else $error("monitor in bypass");
    chk_bypass_drive: assert property (bypass_reg && $past(bypass_reg) |->
        !reg_ctl.over_drive && !reg_ctl.under_drive && !reg_ctl.power_down)
        else $error("drive in bypass");
    chk_pd_off: assert property (reg_ctl.power_down |->
        !reg_ctl.main_regulator && !reg_ctl.low_power_regulator && clk_ctl == '0)
        else $error("power down");
    chk_stop_gated: assert property (
        reg_ctl.low_power_regulator || reg_ctl.under_drive |-> !clk_ctl.core_clk_en)
        else $error("stop clocks");
    chk_cpu_core: assert property (clk_ctl.cpu_clk_en |-> clk_ctl.core_clk_en)
        else $error("cpu clock");
    chk_pll_order: assert property ($rose(clk_ctl.pll_en) && $past(rst_n, 2) |->
        $past(clk_ctl.ext_high_speed_osc_en || clk_ctl.int_high_speed_rc_en))
        else $error("pll order");
endmodule
bind lpmc_top lpmc_sva u_sva (.clk(clk), .rst_n(rst_n), .bypass_reg(bypass_reg),
    .core_por_pin_n(core_por_pin_n), .reg_ctl(reg_ctl), .clk_ctl(clk_ctl),
    .core_por_gpio_en(core_por_gpio_en), .debug_por_en(debug_por_en));

//--- bench/lpmc_far.sv
// model of supply supervisor, oscillators and wake sources
`timescale 1ns/100ps
module lpmc_far
    import lpmc_pkg::*;
(
    input wire logic clk,
    output logic core_por_pin_n,
    output logic [WK_W-1:0] wake_src,
    output logic [2:0] osc
);
    // ----
    // far-side drivers
    // ----
    initial begin
        core_por_pin_n = 1'b1;
        wake_src = '0;
        osc = 3'h0;
    end
    // oscillators toggle at three rates
    always @(posedge clk) begin
        osc <= osc + 3'h1;
    end
    task automatic por(input logic v);
        core_por_pin_n <= v;
    endtask
    // wake pulse on the chosen sources
    task automatic pulse(input logic [WK_W-1:0] v);
        wake_src <= v;
        repeat (2) @(posedge clk);
        wake_src <= '0;
    endtask
endmodule

//--- bench/lpmc_top_test.sv
// testbench: register-level tests of the mode controller
`timescale 1ns/100ps
module lpmc_top_test
    import lpmc_pkg::*;
;
    logic clk, rst_n, byp, batt, pirq, por_n, crst_n, irq, gpio, dbg, rtc, rrun, q;
    logic [3:0] ws;
    logic awv, wv, bq, arv, rq, awr, wrd, bv, arr, rv;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdat, d;
    logic [1:0] rresp, r, br;
    logic [WK_W-1:0] wk;
    logic [2:0] osc;
    lpmc_reg_ctl_t rc;
    lpmc_clk_ctl_t cc;
    int num_errors = 0;
    int checks = 0;
    int lo;
    logic [31:0] bad [4] = '{32'h105, 32'h111, 32'h10A, 32'h11A};
    lpmc_top #(.OSC_WAIT(2), .RST_WAIT(2)) u_dut (.clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bq), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rq), .bypass_reg(byp), .core_por_pin_n(por_n),
        .system_reset_pin_n(rst_n), .battery_supply_mode(batt),
        .external_event_lines(wk[15:0]), .supply_level_detector(1'b0), .usb_wakeup(1'b0),
        .eth_wakeup(1'b0), .low_power_timer(1'b0), .rtc_evt(wk[19:16]), .periph_irq(pirq),
        .ext_low_speed_osc(osc[2]), .int_low_speed_rc(osc[1]), .ext_high_speed_osc(osc[0]),
        .reg_ctl(rc), .clk_ctl(cc), .core_rst_n(crst_n), .core_por_gpio_en(gpio),
        .debug_por_en(dbg), .rtc_clk(rtc), .rtc_run(rrun), .irq(irq));
    lpmc_far u_far (.clk(clk), .core_por_pin_n(por_n), .wake_src(wk), .osc(osc));
    // ----
    // bus and check tasks
    // ----
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 200) begin
            num_errors++;
            $display("BAD wait timeout");
            close_out();
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge clk);
        awa <= a;
        wd <= v;
        {awv, wv, bq} <= 3'h7;
        do begin
            @(posedge clk);
            n++;
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv && n < 200);
        r = br;
        bq <= 1'b0;
        tmo(n);
    endtask
    task automatic bus_rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk);
        ara <= a;
        {arv, rq} <= 2'h3;
        do begin
            @(posedge clk);
            n++;
            if (arr) arv <= 1'b0;
        end while (!rv && n < 200);
        d = rdat;
        r = rresp;
        rq <= 1'b0;
        tmo(n);
    endtask
    // waits for a clock-enable pattern, counting core reset cycles
    task automatic wclk(input logic [4:0] w);
        int n;
        lo = 0;
        for (n = 0; n < 200 && cc !== w; n++) begin
            @(posedge clk);
            lo += (crst_n === 1'b0);
        end
        tmo(n);
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        {rst_n, byp, batt, pirq, awv, wv, bq, arv, rq} = 9'h0;
        {ws, awa, ara, wd} = 52'hF_0000_0000_0000;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk("run clocks", cc, 32'h1F);
        bus_rd(LPMC_WKEN_OFF);
        chk("wake enable", d, 32'hFFFF_FFFF);
        bus_rd(8'h14);
        chk("unmapped", r, 32'h2);
        bus_wr(8'h14, 32'h0);
        chk("unmapped wr", r, 32'h2);
        bus_wr(LPMC_CTRL_OFF, bad[0]);
        chk("masked irq", irq, 32'h0);
        bus_wr(LPMC_IRQM_OFF, 32'h7);
        foreach (bad[i]) begin
            bus_wr(LPMC_CTRL_OFF, bad[i]);
            repeat (2) @(posedge clk);
            chk("refused clk", cc, 32'h1F);
            chk("refused irq", irq, 32'h1);
            bus_rd(LPMC_IRQS_OFF);
            chk("refused stat", d, 32'h1);
        end
        ws <= 4'h1;
        bus_wr(LPMC_CTRL_OFF, bad[0]);
        ws <= 4'hF;
        @(posedge clk);
        chk("irq cleared", irq, 32'h0);
        $display("done refusals");
        bus_wr(LPMC_CTRL_OFF, 32'h116);
        repeat (10) @(posedge clk);
        chk("stop clk", cc, 32'h0);
        chk("stop reg", {rc.low_power_regulator, rc.under_drive}, 32'h3);
        u_far.pulse(20'h00020);
        wclk(5'h1F);
        chk("wake reg", {rc.main_regulator, rc.under_drive}, 32'h2);
        bus_rd(LPMC_IRQS_OFF);
        chk("wake stat", d, 32'h2);
        bus_wr(LPMC_CTRL_OFF, 32'h101);
        repeat (3) @(posedge clk);
        chk("sleep clk", cc, 32'h0F);
        pirq <= 1'b1;
        wclk(5'h1F);
        pirq <= 1'b0;
        $display("done stop and sleep");
        bus_wr(LPMC_CTRL_OFF, 32'h103);
        repeat (3) @(posedge clk);
        chk("standby pd", rc.power_down, 32'h1);
        chk("standby clk", cc, 32'h0);
        u_far.pulse(20'h80000);
        wclk(5'h1F);
        chk("core restart", lo >= 3, 32'h1);
        $display("done standby");
        batt <= 1'b1;
        bus_wr(LPMC_CTRL_OFF, 32'h40);
        repeat (2) @(posedge clk);
        chk("rc in battery", rrun, 32'h0);
        bus_wr(LPMC_CTRL_OFF, 32'h20);
        repeat (2) @(posedge clk);
        chk("ls in battery", rrun, 32'h1);
        bus_wr(LPMC_CTRL_OFF, 32'h60);
        repeat (4) @(posedge clk);
        lo = 0;
        q = rtc;
        repeat (128) begin
            @(posedge clk);
            lo += (rtc && !q);
            q = rtc;
        end
        chk("rtc div", lo, 32'h2);
        batt <= 1'b0;
        $display("done rtc");
        byp <= 1'b1;
        repeat (3) @(posedge clk);
        chk("gpio en", gpio, 32'h0);
        chk("bypass mon", {rc.vscale_en, rc.vmon_en}, 32'h0);
        bus_rd(LPMC_STAT_OFF);
        chk("stat bypass", d[8], 32'h1);
        bus_wr(LPMC_CTRL_OFF, 32'h103);
        bus_rd(LPMC_IRQS_OFF);
        chk("no standby", d[0], 32'h1);
        bus_wr(LPMC_CTRL_OFF, 32'h108);
        bus_rd(LPMC_IRQS_OFF);
        chk("no drive", d[0], 32'h1);
        u_far.por(1'b0);
        repeat (3) @(posedge clk);
        chk("debug", dbg, 32'h0);
        chk("core por", crst_n, 32'h0);
        u_far.por(1'b1);
        $display("done bypass");
        close_out();
    end
endmodule
